//--- logic/scp_consts.svh
// Register byte addresses, field positions, reset values and timing figures for class policy
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

`define SCP_ADDR_IPMAP_LO   8'h3F
`define SCP_ADDR_IPMAP_HI   8'h40
`define SCP_ADDR_TAGMAP_LO  8'h41
`define SCP_ADDR_TAGMAP_HI  8'h42
`define SCP_ADDR_WEIGHT_LO  8'h43
`define SCP_ADDR_WEIGHT_HI  8'h44
`define SCP_ADDR_RSVD_LO    8'h45
`define SCP_ADDR_RSVD_HI    8'h46
`define SCP_ADDR_RESOLVE    8'h47
`define SCP_ADDR_MIRROR_LO  8'h48
`define SCP_ADDR_MIRROR_HI  8'h49
`define SCP_ADDR_AGEFILT    8'h4A

// Class resolution register fields
`define SCP_RES_IP_EN       0
`define SCP_RES_TAG_EN      1
`define SCP_RES_MODE        2
`define SCP_RES_TAG_FIRST   3
`define SCP_RES_DEF_LSB     4
`define SCP_RES_MASK        8'h3F
`define SCP_RES_RESET       8'h14

// Mirror register fields
`define SCP_MIR_SRC_LSB     0
`define SCP_MIR_DST_LSB     4
`define SCP_MIR_RX_EN       8
`define SCP_MIR_TX_EN       9
`define SCP_MIR_MASK        16'h0377
`define SCP_MIR_RESET       16'h0000

// Queue weight register: weight fields every four bits
`define SCP_WGT_MASK        16'h7777
`define SCP_WGT_RESET       16'h0000
`define SCP_MAP_RESET       16'h0000

// Aging and filter register fields
`define SCP_AGE_SEL_LSB     0
`define SCP_AGE_DIS         2
`define SCP_FWD_FCS         3
`define SCP_FWD_SHORT       4
`define SCP_DROP_MACCTL     5
`define SCP_DROP_RSVD       6
`define SCP_AGEFILT_MASK    8'h7F
`define SCP_AGEFILT_RESET   8'h01

// Address lifetime step per aging code, in seconds
`define SCP_AGE_STEP_S      11'd300

// Filtered frame fields
`define SCP_MACCTL_TYPE     16'h8808
`define SCP_RSVD_GROUP_HI   44'h0180C20000_0

`endif

//--- logic/scp_pkg.sv
// Types shared by the class policy block
package scp_pkg;

   // Frame descriptor offered for classification and filtering
   typedef struct packed {
      logic        valid;
      logic        ip_found;
      logic [2:0]  ip_prec;
      logic        tag_found;
      logic [2:0]  user_prio;
      logic        port_pri_en;
      logic [1:0]  port_class;
      logic        fcs_error;
      logic        short_frame;
      logic [15:0] ether_type;
      logic [47:0] dest_addr;
      logic [2:0]  rx_port;
   } scp_frame_type;

   // Verdict for one frame
   typedef struct packed {
      logic       valid;
      logic [1:0] class_id;
      logic       drop;
      logic       mirror_copy;
   } scp_verdict_type;

   // Transmit event from one port
   typedef struct packed {
      logic       valid;
      logic [2:0] tx_port;
   } scp_tx_event_type;

   // Source ordering used by the resolver
   typedef enum logic [1:0] {
      SCP_SRC_IP   = 2'b00,
      SCP_SRC_TAG  = 2'b01,
      SCP_SRC_PORT = 2'b10,
      SCP_SRC_DEF  = 2'b11
   } scp_source_type;

endpackage : scp_pkg

//--- logic/scp_weight_decode.sv
// Decoder from 3-bit queue weight codes to relative weights and their total
`timescale 1ns/1ps
`include "scp_consts.svh"

module scp_weight_decode #(
   parameter int QUEUES = 4
) (
   input  wire logic [15:0]         weight_reg,
   output logic      [QUEUES*6-1:0] weight_vec,
   output logic      [7:0]          weight_sum
);

   // Codes 110 and 111 are unused; they decode to zero so the queue takes no share
   function automatic logic [5:0] decode_weight(input logic [2:0] code);
      logic [5:0] w;
      w = 6'h00;
      if (code <= 3'h5) begin
         w = 6'h01 << code;                                            // R4
      end
      return w;
   endfunction : decode_weight

   // One decoder per queue, field y at bits 4y+2..4y
   genvar q;
   generate
      for (q = 0; q < QUEUES; q++) begin : g_queue
         assign weight_vec[q*6 +: 6] = decode_weight(weight_reg[q*4 +: 3]); // R3
      end
   endgenerate

   // Total of decoded weights; share of queue y is weight y over this sum
   always_comb begin
      weight_sum = 8'h00;
      for (int i = 0; i < QUEUES; i++) begin
         weight_sum = weight_sum + {2'b00, weight_vec[i*6 +: 6]};      // R3
      end
   end

endmodule : scp_weight_decode

//--- logic/scp_policy.sv
// Class of service, mirroring, aging and frame filter policy for the switch core
//
// What this block does
// R1: Eight 2-bit IP precedence fields map precedence 0..7 to class 0..3.
// R2: Eight 2-bit tag user-priority fields map priority 0..7 to class 0..3.
// R3: Four 3-bit queue weights; share equals decoded weight over total.
// R4: Weight codes 000..101 decode to 1,2,4,8,16,32; 110 and 111 unused.
// R5: IP enable set makes IP precedence a considered class source.
// R6: Tag enable set makes tag user priority a considered class source.
// R7: Mode 0 gives the highest class of all enabled sources.
// R8: Mode 1 takes first found source, then port priority, then default class.
// R9: Ordered mode: order bit 1 ranks tag first, 0 ranks IP first.
// R10: Default class, bits 5-4, reset 01, used when nothing else applies.
// R11: Monitored port bits 2-0, monitoring port bits 6-4, one monitored port.
// R12: Receive mirror bit 8 copies frames received on monitored port.
// R13: Transmit mirror bit 9 copies frames sent by monitored port.
// R14: Aging code selects 300, 600, 900 or 1200 seconds, reset code 01.
// R15: Aging disable bit 2 stops removal of learned entries by age.
// R16: Bit 3 forwards frames with a bad check sequence instead of dropping.
// R17: Bit 4 forwards undersized frames instead of dropping them.
// R18: MAC control drop bit discards frames of type 8808.
// R19: Reserved group drop discards reserved group addresses except bridge group.
// R20: IP enable, tag enable and reserved drop reset from strap levels.
// R21: Configuration writes affect only frames offered after the write.
`timescale 1ns/1ps
`include "scp_consts.svh"

module scp_policy #(
   parameter int QUEUES = 4
) (
   input  wire logic                     sys_clk,
   input  wire logic                     rstn,
   input  wire logic                     strap_ip_priority_enable,
   input  wire logic                     strap_tag_priority_enable,
   input  wire logic                     strap_drop_reserved_group_da,
   input  wire logic [7:0]               cfg_addr,
   input  wire logic                     cfg_wr_en,
   input  wire logic [7:0]               cfg_wdata,
   output logic      [7:0]               cfg_rdata,
   input  wire scp_pkg::scp_frame_type    frame_in,
   output scp_pkg::scp_verdict_type       verdict,
   input  wire scp_pkg::scp_tx_event_type tx_event,
   output logic                          tx_mirror_copy,
   output logic      [2:0]               mirror_target_port,
   output logic      [QUEUES*6-1:0]      queue_weights,
   output logic      [7:0]               queue_weight_total,
   output logic      [10:0]              aging_lifetime_s,
   output logic                          aging_enable
);

   // Configuration registers
   logic [15:0] ip_precedence_class_map_q, ip_precedence_class_map_d;
   logic [15:0] vlan_user_priority_class_map_q, vlan_user_priority_class_map_d;
   logic [15:0] class_queue_weights_q, class_queue_weights_d;
   logic [7:0]  class_resolution_config_q, class_resolution_config_d;
   logic [15:0] traffic_mirror_config_q, traffic_mirror_config_d;
   logic [7:0]  aging_and_filter_config_q, aging_and_filter_config_d;

   // Output registers
   logic [7:0]               cfg_rdata_d;
   scp_pkg::scp_verdict_type verdict_d;
   logic                     tx_mirror_copy_d;
   logic [2:0]               mirror_target_port_d;
   logic [QUEUES*6-1:0]      queue_weights_d;
   logic [7:0]               queue_weight_total_d;
   logic [10:0]              aging_lifetime_s_d;
   logic                     aging_enable_d;

   // Decoded fields
   logic       ip_priority_enable;
   logic       tag_priority_enable;
   logic       resolution_mode;
   logic       tag_first_precedence;
   logic [1:0] default_class;
   logic [2:0] monitored_port;
   logic [2:0] monitoring_port;
   logic       rx_mirror_enable;
   logic       tx_mirror_enable;
   logic [1:0] aging_time_select;
   logic       aging_disable;
   logic       fwd_fcs_error_frames;
   logic       fwd_short_frames;
   logic       drop_mac_control_type;
   logic       drop_reserved_group_da;

   assign ip_priority_enable     = class_resolution_config_q[`SCP_RES_IP_EN];
   assign tag_priority_enable    = class_resolution_config_q[`SCP_RES_TAG_EN];
   assign resolution_mode        = class_resolution_config_q[`SCP_RES_MODE];
   assign tag_first_precedence   = class_resolution_config_q[`SCP_RES_TAG_FIRST];
   assign default_class          = class_resolution_config_q[`SCP_RES_DEF_LSB +: 2];
   assign monitored_port         = traffic_mirror_config_q[`SCP_MIR_SRC_LSB +: 3];
   assign monitoring_port        = traffic_mirror_config_q[`SCP_MIR_DST_LSB +: 3];
   assign rx_mirror_enable       = traffic_mirror_config_q[`SCP_MIR_RX_EN];
   assign tx_mirror_enable       = traffic_mirror_config_q[`SCP_MIR_TX_EN];
   assign aging_time_select      = aging_and_filter_config_q[`SCP_AGE_SEL_LSB +: 2];
   assign aging_disable          = aging_and_filter_config_q[`SCP_AGE_DIS];
   assign fwd_fcs_error_frames   = aging_and_filter_config_q[`SCP_FWD_FCS];
   assign fwd_short_frames       = aging_and_filter_config_q[`SCP_FWD_SHORT];
   assign drop_mac_control_type  = aging_and_filter_config_q[`SCP_DROP_MACCTL];
   assign drop_reserved_group_da = aging_and_filter_config_q[`SCP_DROP_RSVD];

   // Class lookup in a packed eight-entry map, shared by the IP and tag tables
   function automatic logic [1:0] map_class(input logic [15:0] map, input logic [2:0] idx);
      return map[{idx, 1'b0} +: 2];
   endfunction : map_class

   // Weight decoder; combinational, registered below
   logic [QUEUES*6-1:0] weight_vec;
   logic [7:0]          weight_sum;

   scp_weight_decode #(
      .QUEUES     (QUEUES)
   ) u_weight_decode (
      .weight_reg (class_queue_weights_q),
      .weight_vec (weight_vec),
      .weight_sum (weight_sum)
   );

   // Register writes, byte wide; 16-bit registers have their low byte at the lower address.
   // Straps are sampled while reset is held, so the value at the release is kept.
   always_comb begin
      ip_precedence_class_map_d      = ip_precedence_class_map_q;
      vlan_user_priority_class_map_d = vlan_user_priority_class_map_q;
      class_queue_weights_d          = class_queue_weights_q;
      class_resolution_config_d      = class_resolution_config_q;
      traffic_mirror_config_d        = traffic_mirror_config_q;
      aging_and_filter_config_d      = aging_and_filter_config_q;
      if (!rstn) begin
         ip_precedence_class_map_d      = `SCP_MAP_RESET;
         vlan_user_priority_class_map_d = `SCP_MAP_RESET;
         class_queue_weights_d          = `SCP_WGT_RESET;
         class_resolution_config_d      = `SCP_RES_RESET;                     // R10
         class_resolution_config_d[`SCP_RES_IP_EN]  = strap_ip_priority_enable;  // R20
         class_resolution_config_d[`SCP_RES_TAG_EN] = strap_tag_priority_enable; // R20
         traffic_mirror_config_d        = `SCP_MIR_RESET;
         aging_and_filter_config_d      = `SCP_AGEFILT_RESET;                 // R14
         aging_and_filter_config_d[`SCP_DROP_RSVD] = strap_drop_reserved_group_da; // R20
      end else if (cfg_wr_en) begin
         unique case (cfg_addr)
            `SCP_ADDR_IPMAP_LO:  ip_precedence_class_map_d[7:0]       = cfg_wdata; // R1
            `SCP_ADDR_IPMAP_HI:  ip_precedence_class_map_d[15:8]      = cfg_wdata; // R1
            `SCP_ADDR_TAGMAP_LO: vlan_user_priority_class_map_d[7:0]  = cfg_wdata; // R2
            `SCP_ADDR_TAGMAP_HI: vlan_user_priority_class_map_d[15:8] = cfg_wdata; // R2
            `SCP_ADDR_WEIGHT_LO: begin
               class_queue_weights_d[7:0]  = cfg_wdata & 8'h77;                    // R3
            end
            `SCP_ADDR_WEIGHT_HI: begin
               class_queue_weights_d[15:8] = cfg_wdata & 8'h77;                    // R3
            end
            `SCP_ADDR_RESOLVE:   class_resolution_config_d = cfg_wdata & `SCP_RES_MASK;
            `SCP_ADDR_MIRROR_LO: traffic_mirror_config_d[7:0] = cfg_wdata & 8'h77;   // R11
            `SCP_ADDR_MIRROR_HI: traffic_mirror_config_d[15:8] = cfg_wdata & 8'h03;  // R11
            `SCP_ADDR_AGEFILT:   aging_and_filter_config_d = cfg_wdata & `SCP_AGEFILT_MASK;
            default: begin
               // Reserved and unmapped addresses take no write
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      ip_precedence_class_map_q      <= ip_precedence_class_map_d;
      vlan_user_priority_class_map_q <= vlan_user_priority_class_map_d;
      class_queue_weights_q          <= class_queue_weights_d;
      class_resolution_config_q      <= class_resolution_config_d;
      traffic_mirror_config_q        <= traffic_mirror_config_d;
      aging_and_filter_config_q      <= aging_and_filter_config_d;
   end

   // Read data one cycle after the address; reserved and unmapped bytes read zero
   always_comb begin
      cfg_rdata_d = 8'h00;
      unique case (cfg_addr)
         `SCP_ADDR_IPMAP_LO:  cfg_rdata_d = ip_precedence_class_map_q[7:0];
         `SCP_ADDR_IPMAP_HI:  cfg_rdata_d = ip_precedence_class_map_q[15:8];
         `SCP_ADDR_TAGMAP_LO: cfg_rdata_d = vlan_user_priority_class_map_q[7:0];
         `SCP_ADDR_TAGMAP_HI: cfg_rdata_d = vlan_user_priority_class_map_q[15:8];
         `SCP_ADDR_WEIGHT_LO: cfg_rdata_d = class_queue_weights_q[7:0];
         `SCP_ADDR_WEIGHT_HI: cfg_rdata_d = class_queue_weights_q[15:8];
         `SCP_ADDR_RESOLVE:   cfg_rdata_d = class_resolution_config_q;
         `SCP_ADDR_MIRROR_LO: cfg_rdata_d = traffic_mirror_config_q[7:0];
         `SCP_ADDR_MIRROR_HI: cfg_rdata_d = traffic_mirror_config_q[15:8];
         `SCP_ADDR_AGEFILT:   cfg_rdata_d = aging_and_filter_config_q;
         default:             cfg_rdata_d = 8'h00;
      endcase
      if (!rstn) begin
         cfg_rdata_d = 8'h00;
      end
   end

   // Candidate classes of each source, valid only when enabled and present
   logic       ip_hit;
   logic       tag_hit;
   logic       port_hit;
   logic [1:0] ip_class;
   logic [1:0] tag_class;
   logic [1:0] port_class;
   logic [1:0] best_class;
   logic [1:0] ordered_class;

   assign ip_hit     = ip_priority_enable && frame_in.ip_found;      // R5
   assign tag_hit    = tag_priority_enable && frame_in.tag_found;    // R6
   assign port_hit   = frame_in.port_pri_en;
   assign ip_class   = map_class(ip_precedence_class_map_q, frame_in.ip_prec);        // R1
   assign tag_class  = map_class(vlan_user_priority_class_map_q, frame_in.user_prio); // R2
   assign port_class = frame_in.port_class;

   // Highest class among enabled sources, default class when none applies
   always_comb begin
      best_class = 2'h0;
      if (ip_hit && ip_class > best_class) begin
         best_class = ip_class;                                       // R7
      end
      if (tag_hit && tag_class > best_class) begin
         best_class = tag_class;                                      // R7
      end
      if (port_hit && port_class > best_class) begin
         best_class = port_class;                                     // R7
      end
      if (!ip_hit && !tag_hit && !port_hit) begin
         best_class = default_class;                                  // R10
      end
   end

   // First source found in the configured order
   always_comb begin
      scp_pkg::scp_source_type pick;
      pick = scp_pkg::SCP_SRC_DEF;
      if (tag_first_precedence) begin                                 // R9
         if (tag_hit)       pick = scp_pkg::SCP_SRC_TAG;
         else if (ip_hit)   pick = scp_pkg::SCP_SRC_IP;
         else if (port_hit) pick = scp_pkg::SCP_SRC_PORT;
      end else begin
         if (ip_hit)        pick = scp_pkg::SCP_SRC_IP;
         else if (tag_hit)  pick = scp_pkg::SCP_SRC_TAG;
         else if (port_hit) pick = scp_pkg::SCP_SRC_PORT;
      end
      unique case (pick)
         scp_pkg::SCP_SRC_IP:   ordered_class = ip_class;             // R8
         scp_pkg::SCP_SRC_TAG:  ordered_class = tag_class;            // R8
         scp_pkg::SCP_SRC_PORT: ordered_class = port_class;           // R8
         scp_pkg::SCP_SRC_DEF:  ordered_class = default_class;        // R10
      endcase
   end

   // Filter decisions for the offered frame
   logic rsvd_group_da;
   logic frame_drop;

   assign rsvd_group_da = (frame_in.dest_addr[47:4] == `SCP_RSVD_GROUP_HI)
                          && (frame_in.dest_addr[3:0] != 4'h0);       // R19
   assign frame_drop    = (frame_in.fcs_error && !fwd_fcs_error_frames)       // R16
                          || (frame_in.short_frame && !fwd_short_frames)      // R17
                          || (drop_mac_control_type
                              && frame_in.ether_type == `SCP_MACCTL_TYPE)     // R18
                          || (drop_reserved_group_da && rsvd_group_da);       // R19

   // Verdict, mirror and status outputs; decided from the settings in force at the offer edge,
   // so a later write never changes a verdict already issued
   always_comb begin
      verdict_d             = '0;
      tx_mirror_copy_d      = 1'b0;
      mirror_target_port_d  = monitoring_port;                        // R11
      queue_weights_d       = weight_vec;                             // R4
      queue_weight_total_d  = weight_sum;                             // R3
      aging_enable_d        = !aging_disable;                         // R15
      aging_lifetime_s_d    = 11'(`SCP_AGE_STEP_S * ({9'h000, aging_time_select} + 11'h001)); // R14
      if (frame_in.valid) begin                                       // R21
         verdict_d.valid       = 1'b1;
         verdict_d.class_id    = resolution_mode ? ordered_class : best_class; // R7
         verdict_d.drop        = frame_drop;
         verdict_d.mirror_copy = rx_mirror_enable
                                 && frame_in.rx_port == monitored_port;  // R12
      end
      if (tx_event.valid) begin
         tx_mirror_copy_d = tx_mirror_enable && tx_event.tx_port == monitored_port; // R13
      end
      if (!rstn) begin
         verdict_d            = '0;
         tx_mirror_copy_d     = 1'b0;
         mirror_target_port_d = 3'h0;
         queue_weights_d      = '0;
         queue_weight_total_d = 8'h00;
         aging_enable_d       = 1'b0;
         aging_lifetime_s_d   = 11'h000;
      end
   end

   always_ff @(posedge sys_clk) begin
      cfg_rdata          <= cfg_rdata_d;
      verdict            <= verdict_d;
      tx_mirror_copy     <= tx_mirror_copy_d;
      mirror_target_port <= mirror_target_port_d;
      queue_weights      <= queue_weights_d;
      queue_weight_total <= queue_weight_total_d;
      aging_lifetime_s   <= aging_lifetime_s_d;
      aging_enable       <= aging_enable_d;
   end

endmodule : scp_policy

//--- verification/scp_policy_sva.sv
// Assertion checker for the class policy block
`timescale 1ns/1ps

module scp_policy_sva #(
   parameter int QUEUES = 4
) (
   input wire logic                      sys_clk,
   input wire logic                      rstn,
   input wire logic [7:0]                cfg_addr,
   input wire logic                      cfg_wr_en,
   input wire logic [7:0]                cfg_wdata,
   input wire logic [7:0]                cfg_rdata,
   input wire scp_pkg::scp_frame_type    frame_in,
   input wire scp_pkg::scp_verdict_type  verdict,
   input wire scp_pkg::scp_tx_event_type tx_event,
   input wire logic                      tx_mirror_copy,
   input wire logic [2:0]                mirror_target_port,
   input wire logic [QUEUES*6-1:0]       queue_weights,
   input wire logic [7:0]                queue_weight_total,
   input wire logic [10:0]               aging_lifetime_s,
   input wire logic                      aging_enable
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   // A write strobe to one byte; status outputs lag it by two edges
   sequence s_wr(logic [7:0] a);
      cfg_wr_en && cfg_addr == a;
   endsequence

   a_verdict_follows: assert property (frame_in.valid |=> verdict.valid)
      else $error("verdict missing after frame offer");
   a_verdict_idle: assert property (!frame_in.valid |=> verdict == '0)
      else $error("verdict without frame offer");
   a_tx_copy_cause: assert property (tx_mirror_copy |-> $past(tx_event.valid))
      else $error("transmit copy without transmit event");
   a_weight_total: assert property (queue_weight_total == queue_weights[5:0] +
      queue_weights[11:6] + queue_weights[17:12] + queue_weights[23:18])
      else $error("weight total differs from sum of weights");
   a_weight_decode: assert property (s_wr(8'h43) |-> ##2 queue_weights[5:0] ==
      (($past(cfg_wdata[2:0], 2) < 3'h6) ? (6'h01 << $past(cfg_wdata[2:0], 2)) : 6'h00))
      else $error("queue zero weight decode wrong");
   a_age_life: assert property (s_wr(8'h4A) |-> ##2
      aging_lifetime_s == 11'h12C * ($past(cfg_wdata[1:0], 2) + 11'h001))
      else $error("aging lifetime wrong");
   a_age_enable: assert property (s_wr(8'h4A) |-> ##2 aging_enable == !$past(cfg_wdata[2], 2))
      else $error("aging enable wrong");
   a_mirror_port: assert property (s_wr(8'h48) |-> ##2
      mirror_target_port == $past(cfg_wdata[6:4], 2))
      else $error("monitoring port wrong");
   a_resolve_readback: assert property (s_wr(8'h47) ##1 cfg_addr == 8'h47 |=>
      cfg_rdata == ($past(cfg_wdata, 2) & 8'h3F))
      else $error("resolution register readback wrong");
endmodule : scp_policy_sva

bind scp_policy scp_policy_sva #(.QUEUES(QUEUES)) i_scp_policy_sva (.sys_clk(sys_clk),
   .rstn(rstn), .cfg_addr(cfg_addr), .cfg_wr_en(cfg_wr_en), .cfg_wdata(cfg_wdata),
   .cfg_rdata(cfg_rdata), .frame_in(frame_in), .verdict(verdict), .tx_event(tx_event),
   .tx_mirror_copy(tx_mirror_copy), .mirror_target_port(mirror_target_port),
   .queue_weights(queue_weights), .queue_weight_total(queue_weight_total),
   .aging_lifetime_s(aging_lifetime_s), .aging_enable(aging_enable));

//--- verification/scp_policy_test.sv
// Self-checking bench for the class policy block
`timescale 1ns/1ps

module scp_policy_test;
   logic                      sys_clk, rstn, cfg_wr_en, tx_mirror_copy, aging_enable, exp_tx;
   logic [2:0]                strap, mirror_target_port;
   logic [7:0]                cfg_addr, cfg_wdata, cfg_rdata, queue_weight_total, exp_rd;
   logic [23:0]               queue_weights;
   logic [10:0]               aging_lifetime_s;
   logic [31:0]               seed = 32'h00000027;
   logic [7:0]                sh [0:255];
   logic [7:0]                al [0:13] = '{8'h3F, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45,
                                            8'h46, 8'h47, 8'h48, 8'h49, 8'h4A, 8'h80, 8'hFF};
   scp_pkg::scp_frame_type    frame_in, fr;
   scp_pkg::scp_verdict_type  verdict, exp_v;
   scp_pkg::scp_tx_event_type tx_event;
   int                        n_fail = 0;
   int                        n_tests = 0;

   scp_policy i_scp_policy (.sys_clk(sys_clk), .rstn(rstn), .strap_ip_priority_enable(strap[0]),
      .strap_tag_priority_enable(strap[1]), .strap_drop_reserved_group_da(strap[2]),
      .cfg_addr(cfg_addr), .cfg_wr_en(cfg_wr_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .frame_in(frame_in), .verdict(verdict), .tx_event(tx_event),
      .tx_mirror_copy(tx_mirror_copy), .mirror_target_port(mirror_target_port),
      .queue_weights(queue_weights), .queue_weight_total(queue_weight_total),
      .aging_lifetime_s(aging_lifetime_s), .aging_enable(aging_enable));

   // 40 MHz core clock
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Sixteen steps per call so successive values share few bits
   function automatic logic [31:0] lfsr(logic [31:0] s);
      repeat (16) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      return s;
   endfunction : lfsr

   // Writable bits per byte; reserved and unmapped bytes keep nothing
   function automatic logic [7:0] msk(logic [7:0] a);
      case (a)
         8'h3F, 8'h40, 8'h41, 8'h42: return 8'hFF;
         8'h43, 8'h44, 8'h48: return 8'h77;
         8'h47: return 8'h3F;
         8'h49: return 8'h03;
         8'h4A: return 8'h7F;
         default: return 8'h00;
      endcase
   endfunction : msk

   function automatic logic [5:0] w(int c);
      return (c % 8 < 6) ? (6'h01 << (c % 8)) : 6'h00;
   endfunction : w

   // Reference verdict from the shadow registers as they stand before this cycle's write
   function automatic scp_pkg::scp_verdict_type model(scp_pkg::scp_frame_type f);
      int q[$];
      int r;
      logic [15:0] m;
      logic [7:0] c;
      logic [7:0] g;
      scp_pkg::scp_verdict_type v;
      c = sh[8'h47];
      g = sh[8'h4A];
      r = 0;
      for (int k = 0; k < 2; k++) begin
         if (k != int'(c[3]) && c[1] && f.tag_found) begin
            m = {sh[8'h42], sh[8'h41]} >> (2 * f.user_prio);
            q.push_back(m[1:0]);
         end
         if (k == int'(c[3]) && c[0] && f.ip_found) begin
            m = {sh[8'h40], sh[8'h3F]} >> (2 * f.ip_prec);
            q.push_back(m[1:0]);
         end
      end
      if (f.port_pri_en) q.push_back(f.port_class);
      foreach (q[i]) if (q[i] > r) r = q[i];
      v.valid = 1'b1;
      v.class_id = (q.size() == 0) ? c[5:4] : (c[2] ? q[0] : r);
      v.drop = (f.fcs_error && !g[3]) || (f.short_frame && !g[4]) ||
         (g[5] && f.ether_type == 16'h8808) ||
         (g[6] && f.dest_addr[47:4] == 44'h0180C200000 && f.dest_addr[3:0] != 4'h0);
      v.mirror_copy = sh[8'h49][0] && f.rx_port == sh[8'h48][2:0];
      if (!f.valid) v = '0;
      return v;
   endfunction : model

   task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR %s expected %0h seen %0h", nm, e, s);
      end
   endtask : chk

   // Strobe stays high across back-to-back writes so it never glitches; the caller lowers it
   task automatic wr(logic [7:0] a, logic [7:0] d);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_wr_en = 1'b1;
      sh[a] = d & msk(a);
      @(negedge sys_clk);
   endtask : wr

   task automatic rd(logic [7:0] a);
      cfg_addr = a;
      cfg_wr_en = 1'b0;
      @(negedge sys_clk);
      chk("read data", sh[a], cfg_rdata);
   endtask : rd

   // Reset with given strap levels, then check outputs, every register byte and two unmapped bytes
   task automatic reset_run(logic [2:0] s);
      rstn = 1'b0;
      strap = s;
      cfg_wr_en = 1'b0;
      cfg_addr = 8'h00;
      cfg_wdata = 8'h00;
      frame_in = '0;
      tx_event = '0;
      repeat (12) @(negedge sys_clk);
      foreach (sh[i]) sh[i] = 8'h00;
      sh[8'h47] = {6'h05, s[1:0]};
      sh[8'h4A] = {1'b0, s[2], 6'h01};
      rstn = 1'b1;
      @(negedge sys_clk);
      chk("status", {11'h258, 1'b1, 8'h04, 3'h0},
         {aging_lifetime_s, aging_enable, queue_weight_total, mirror_target_port});
      chk("weights", 24'h041041, queue_weights);
      foreach (al[i]) rd(al[i]);
      $display("reset test done");
   endtask : reset_run

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize

   // Main sequence: reset, weight and aging sweep, random traffic, second reset
   initial begin
      reset_run(3'h5);
      wr(8'h47, 8'hFF);
      rd(8'h47);
      for (int k = 0; k < 8; k++) begin
         wr(8'h43, {1'b0, k[2:0], 1'b0, k[2:0]});
         wr(8'h44, {1'b0, k[2:0], 1'b0, 3'(k + 1)});
         wr(8'h4A, 8'(k) & 8'h07);
         cfg_wr_en = 1'b0;
         @(negedge sys_clk);
         chk("weights", {w(k), w(k + 1), w(k), w(k)}, queue_weights);
         chk("weight total", w(k) * 3 + w(k + 1), queue_weight_total);
         chk("aging", {11'(11'h12C * (k % 4 + 1)), k[2] == 0},
            {aging_lifetime_s, aging_enable});
      end
      $display("weight and aging test done");
      repeat (3000) begin
         seed = lfsr(seed);
         fr = 81'({seed, lfsr(seed ^ 32'h5A5A5A5A), seed});
         if (seed[3]) fr.ether_type = 16'h8808;
         if (seed[4]) fr.dest_addr = {44'h0180C200000, seed[11:8]};
         frame_in = fr;
         tx_event = seed[14:11];
         cfg_addr = al[seed[23:16] % 14];
         cfg_wr_en = seed[25] & seed[26];
         cfg_wdata = seed[31:24] ^ seed[7:0];
         exp_v = model(frame_in);
         exp_tx = tx_event.valid && sh[8'h49][1] && tx_event.tx_port == sh[8'h48][2:0];
         exp_rd = sh[cfg_addr];
         if (cfg_wr_en) sh[cfg_addr] = cfg_wdata & msk(cfg_addr);
         @(negedge sys_clk);
         chk("verdict", exp_v, verdict);
         chk("tx copy", exp_tx, tx_mirror_copy);
         chk("read data", exp_rd, cfg_rdata);
      end
      $display("random traffic test done");
      reset_run(3'h2);
      summarize();
   end
endmodule : scp_policy_test
